// File: logic/flash_poll_pkg.sv
/*
 * Shared constants and types for the flash status polling controller:
 * register map, control fields, command sequences and strobe timing.
 * Assumes a 40 MHz pclk and a x16 asynchronous flash bus.
 */
`default_nettype none
package flash_poll_pkg;
	localparam int ADDR_W = 24;
	localparam int DQ_W = 16;

	// Register byte offsets on the APB side
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_EXPECT = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;

	// Control field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP_LO = 1;
	localparam int CTRL_RST_PIN = 3;

	// Status field positions
	localparam int ST_BUSY = 0;
	localparam int ST_PASS = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_ABORT = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_RDY = 5;
	localparam int ST_LOCK_F = 6;
	localparam int ST_LOCK_A = 7;
	localparam int ST_BYTE_LO = 8;

	// Status word bit positions
	localparam int B_POLL = 7;
	localparam int B_TOG = 6;
	localparam int B_FAIL = 5;
	localparam int B_ABORT = 1;

	typedef enum logic [1:0] {
		OP_DATA_POLL = 2'd0,
		OP_TOGGLE_POLL = 2'd1,
		OP_RESET1 = 2'd2,
		OP_RESET3 = 2'd3
	} op_t;

	// Command sequence, x16 addressing
	localparam logic [ADDR_W-1:0] SEQ_ADDR0 = 24'h00_0555;
	localparam logic [ADDR_W-1:0] SEQ_ADDR1 = 24'h00_02AA;
	localparam logic [7:0] SEQ_DATA0 = 8'hAA;
	localparam logic [7:0] SEQ_DATA1 = 8'h55;
	localparam logic [7:0] CMD_READ_RESET = 8'hF0;

	// Strobe timing
	localparam int CLK_NS = 25;
	localparam int T_RD_NS = 120;
	localparam int T_WR_NS = 60;
	localparam int T_GAP_NS = 30;
	localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic is_write;
		logic [ADDR_W-1:0] addr;
		logic [DQ_W-1:0] data;
	} cycle_req_t;
endpackage
`default_nettype wire

// File: logic/flash_cycle.sv
/*
 * One asynchronous flash bus cycle, read or write, timed in pclk cycles.
 * Assumes the caller pulses start only while idle and holds nothing else.
 * Done comes at the end of the gap, so a start that answers it lands
 * in idle and is never lost.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_cycle (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire flash_poll_pkg::cycle_req_t req,
	input wire logic [flash_poll_pkg::DQ_W-1:0] dq_in,
	output logic done,
	output logic [flash_poll_pkg::DQ_W-1:0] rdata,
	output logic [flash_poll_pkg::ADDR_W-1:0] a_out,
	output logic [flash_poll_pkg::DQ_W-1:0] dq_out,
	output logic dq_oe_n,
	output logic ce_n,
	output logic oe_n,
	output logic we_n
);
	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_ACT = 3'b010,
		C_GAP = 3'b100
	} cyc_state_t;

	cyc_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic wr_q, wr_d;
	logic done_d, dq_oe_n_d, ce_n_d, oe_n_d, we_n_d;
	logic [flash_poll_pkg::DQ_W-1:0] rdata_d, dq_out_d;
	logic [flash_poll_pkg::ADDR_W-1:0] a_d;

	// Strobe sequencing; data is held through the gap for hold time
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		done_d = 1'b0;
		rdata_d = rdata;
		a_d = a_out;
		dq_out_d = dq_out;
		dq_oe_n_d = dq_oe_n;
		ce_n_d = ce_n;
		oe_n_d = oe_n;
		we_n_d = we_n;
		case (st_q)
			C_IDLE: begin
				if (start) begin
					st_d = C_ACT;
					wr_d = req.is_write;
					cnt_d = req.is_write ? 4'(flash_poll_pkg::WR_CYC - 1)
						: 4'(flash_poll_pkg::RD_CYC - 1);
					a_d = req.addr;
					dq_out_d = req.data;
					dq_oe_n_d = ~req.is_write;
					ce_n_d = 1'b0;
					oe_n_d = req.is_write;
					we_n_d = ~req.is_write;
				end
			end
			C_ACT: begin
				if (cnt_q == 4'h0) begin
					ce_n_d = 1'b1;
					oe_n_d = 1'b1;
					we_n_d = 1'b1;
					if (!wr_q) begin
						rdata_d = dq_in;
					end
					st_d = C_GAP;
					cnt_d = 4'(flash_poll_pkg::GAP_CYC - 1);
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			C_GAP: begin
				if (cnt_q == 4'h0) begin
					dq_oe_n_d = 1'b1;
					done_d = 1'b1;
					st_d = C_IDLE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			default: st_d = C_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= C_IDLE;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			done <= 1'b0;
			rdata <= 16'h0000;
			a_out <= 24'h00_0000;
			dq_out <= 16'h0000;
			dq_oe_n <= 1'b1;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			done <= done_d;
			rdata <= rdata_d;
			a_out <= a_d;
			dq_out <= dq_out_d;
			dq_oe_n <= dq_oe_n_d;
			ce_n <= ce_n_d;
			oe_n <= oe_n_d;
			we_n <= we_n_d;
		end
	end
endmodule
`default_nettype wire

// File: logic/flash_status_host.sv
/*
 * Host controller that polls a parallel NOR flash for the end of an
 * embedded program/erase and issues the recovery resets. Software drives
 * it over APB. Assumes the flash bus is x16 and inputs are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_status_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [flash_poll_pkg::ADDR_W-1:0] fl_addr,
	output logic [flash_poll_pkg::DQ_W-1:0] fl_dq_out,
	input wire logic [flash_poll_pkg::DQ_W-1:0] fl_dq_in,
	output logic fl_dq_oe_n,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n,
	output logic fl_rst_n,
	input wire logic ready_busy_n_in
);
	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_WRITE = 3'b010,
		M_READ = 3'b100
	} main_state_t;

	main_state_t st_q, st_d;
	flash_poll_pkg::op_t op_q, op_d, new_op;
	logic [1:0] step_q, step_d;
	logic first_q, first_d, err_seen_q, err_seen_d;
	logic [7:0] prev_q, prev_d, exp_q, exp_d;
	logic [flash_poll_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic pass_q, pass_d, fail_q, fail_d, abort_q, abort_d;
	logic refused_q, refused_d, fail_lock_q, fail_lock_d;
	logic abort_lock_q, abort_lock_d, rst_pin_q, rst_pin_d;
	logic start_q, start_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d, apb_wr, go, bad_op, finish_fail;
	logic cyc_done;
	logic [flash_poll_pkg::DQ_W-1:0] cyc_rdata;
	logic [7:0] rbyte;
	flash_poll_pkg::cycle_req_t req;

	// Address of one write of a reset sequence
	function automatic logic [flash_poll_pkg::ADDR_W-1:0] seq_addr(
		input flash_poll_pkg::op_t op, input logic [1:0] step);
		if (op == flash_poll_pkg::OP_RESET3 && step == 2'd0) begin
			return flash_poll_pkg::SEQ_ADDR0;
		end else if (op == flash_poll_pkg::OP_RESET3 && step == 2'd1) begin
			return flash_poll_pkg::SEQ_ADDR1;
		end
		return flash_poll_pkg::SEQ_ADDR0;
	endfunction

	// Data of one write of a reset sequence
	function automatic logic [7:0] seq_data(
		input flash_poll_pkg::op_t op, input logic [1:0] step);
		if (op == flash_poll_pkg::OP_RESET3 && step == 2'd0) begin
			return flash_poll_pkg::SEQ_DATA0;
		end else if (op == flash_poll_pkg::OP_RESET3 && step == 2'd1) begin
			return flash_poll_pkg::SEQ_DATA1;
		end
		return flash_poll_pkg::CMD_READ_RESET;
	endfunction

	function automatic logic is_reset(input flash_poll_pkg::op_t op);
		return op == flash_poll_pkg::OP_RESET1 ||
			op == flash_poll_pkg::OP_RESET3;
	endfunction

	// Poll reads always use the software-given address
	always_comb begin
		req.is_write = (st_q == M_WRITE);
		req.addr = (st_q == M_WRITE) ? seq_addr(op_q, step_q) : addr_q;
		req.data = {8'h00, seq_data(op_q, step_q)};
	end

	flash_cycle u_cycle (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_q),
		.req(req),
		.dq_in(fl_dq_in),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.a_out(fl_addr),
		.dq_out(fl_dq_out),
		.dq_oe_n(fl_dq_oe_n),
		.ce_n(fl_ce_n),
		.oe_n(fl_oe_n),
		.we_n(fl_we_n)
	);

	assign rbyte = cyc_rdata[7:0];
	assign apb_wr = psel && penable && pready && pwrite;
	assign go = apb_wr && paddr == flash_poll_pkg::REG_CTRL &&
		pwdata[flash_poll_pkg::CTRL_GO];
	assign new_op = flash_poll_pkg::op_t'(pwdata[flash_poll_pkg::CTRL_OP_LO +: 2]);
	// A locked device accepts only its recovery reset
	assign bad_op = (fail_lock_q && !is_reset(new_op)) ||
		(abort_lock_q && new_op != flash_poll_pkg::OP_RESET3);
	// Error bit seen on an earlier read, and still not finished now
	assign finish_fail = err_seen_q;

	// Sequencer and result flags
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		step_d = step_q;
		first_d = first_q;
		err_seen_d = err_seen_q;
		prev_d = prev_q;
		pass_d = pass_q;
		fail_d = fail_q;
		abort_d = abort_q;
		refused_d = refused_q;
		fail_lock_d = fail_lock_q;
		abort_lock_d = abort_lock_q;
		start_d = 1'b0;
		case (st_q)
			M_IDLE: begin
				if (go && bad_op) begin
					refused_d = 1'b1;
				end else if (go) begin
					op_d = new_op;
					step_d = 2'd0;
					first_d = 1'b1;
					err_seen_d = 1'b0;
					pass_d = 1'b0;
					fail_d = 1'b0;
					abort_d = 1'b0;
					refused_d = 1'b0;
					start_d = 1'b1;
					st_d = is_reset(new_op) ? M_WRITE : M_READ;
				end
			end
			M_WRITE: begin
				if (go) begin
					refused_d = 1'b1;
				end
				if (cyc_done) begin
					if (op_q == flash_poll_pkg::OP_RESET1 || step_q == 2'd2) begin
						pass_d = 1'b1;
						fail_lock_d = 1'b0;
						if (op_q == flash_poll_pkg::OP_RESET3) begin
							abort_lock_d = 1'b0;
						end
						st_d = M_IDLE;
					end else begin
						step_d = step_q + 2'd1;
						start_d = 1'b1;
					end
				end
			end
			M_READ: begin
				if (go) begin
					refused_d = 1'b1;
				end
				if (cyc_done) begin
					prev_d = rbyte;
					first_d = 1'b0;
					start_d = 1'b1;
					// Data poll: true bit back means done; toggle: bit still
					if ((op_q == flash_poll_pkg::OP_DATA_POLL &&
						rbyte[flash_poll_pkg::B_POLL] == exp_q[flash_poll_pkg::B_POLL]) ||
						(op_q == flash_poll_pkg::OP_TOGGLE_POLL && !first_q &&
						rbyte[flash_poll_pkg::B_TOG] == prev_q[flash_poll_pkg::B_TOG])) begin
						pass_d = 1'b1;
						start_d = 1'b0;
						st_d = M_IDLE;
					end else if (op_q == flash_poll_pkg::OP_TOGGLE_POLL && first_q) begin
						err_seen_d = 1'b0;
					end else if (finish_fail) begin
						// Error flags sampled again on this read decide the cause
						fail_d = rbyte[flash_poll_pkg::B_FAIL] ||
							!rbyte[flash_poll_pkg::B_ABORT];
						abort_d = rbyte[flash_poll_pkg::B_ABORT];
						fail_lock_d = fail_lock_q || rbyte[flash_poll_pkg::B_FAIL] ||
							!rbyte[flash_poll_pkg::B_ABORT];
						abort_lock_d = abort_lock_q || rbyte[flash_poll_pkg::B_ABORT];
						start_d = 1'b0;
						st_d = M_IDLE;
					end else if (rbyte[flash_poll_pkg::B_FAIL] ||
						rbyte[flash_poll_pkg::B_ABORT]) begin
						err_seen_d = 1'b1;
					end
				end
			end
			default: st_d = M_IDLE;
		endcase
	end

	// APB slave: zero wait states, answer in the first access cycle
	always_comb begin
		addr_d = addr_q;
		exp_d = exp_q;
		rst_pin_d = rst_pin_q;
		pready_d = psel && !penable;
		pslverr_d = 1'b0;
		prdata_d = prdata;
		if (apb_wr && paddr == flash_poll_pkg::REG_CTRL) begin
			rst_pin_d = pwdata[flash_poll_pkg::CTRL_RST_PIN];
		end else if (apb_wr && paddr == flash_poll_pkg::REG_ADDR) begin
			addr_d = pwdata[flash_poll_pkg::ADDR_W-1:0];
		end else if (apb_wr && paddr == flash_poll_pkg::REG_EXPECT) begin
			exp_d = pwdata[7:0];
		end
		if (psel && !penable) begin
			prdata_d = 32'h0000_0000;
			if (paddr == flash_poll_pkg::REG_CTRL) begin
				prdata_d[flash_poll_pkg::CTRL_OP_LO +: 2] = op_q;
				prdata_d[flash_poll_pkg::CTRL_RST_PIN] = rst_pin_q;
			end else if (paddr == flash_poll_pkg::REG_ADDR) begin
				prdata_d[flash_poll_pkg::ADDR_W-1:0] = addr_q;
			end else if (paddr == flash_poll_pkg::REG_EXPECT) begin
				prdata_d[7:0] = exp_q;
			end else if (paddr == flash_poll_pkg::REG_STATUS) begin
				prdata_d[flash_poll_pkg::ST_BUSY] = (st_q != M_IDLE);
				prdata_d[flash_poll_pkg::ST_PASS] = pass_q;
				prdata_d[flash_poll_pkg::ST_FAIL] = fail_q;
				prdata_d[flash_poll_pkg::ST_ABORT] = abort_q;
				prdata_d[flash_poll_pkg::ST_REFUSED] = refused_q;
				prdata_d[flash_poll_pkg::ST_RDY] = ready_busy_n_in;
				prdata_d[flash_poll_pkg::ST_LOCK_F] = fail_lock_q;
				prdata_d[flash_poll_pkg::ST_LOCK_A] = abort_lock_q;
				prdata_d[flash_poll_pkg::ST_BYTE_LO +: 8] = prev_q;
			end else begin
				pslverr_d = 1'b1;
			end
		end
	end

	// Reset pin held low out of reset so the device starts clean
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= M_IDLE;
			op_q <= flash_poll_pkg::OP_DATA_POLL;
			step_q <= 2'd0;
			first_q <= 1'b1;
			err_seen_q <= 1'b0;
			prev_q <= 8'h00;
			exp_q <= 8'h00;
			addr_q <= 24'h00_0000;
			pass_q <= 1'b0;
			fail_q <= 1'b0;
			abort_q <= 1'b0;
			refused_q <= 1'b0;
			fail_lock_q <= 1'b0;
			abort_lock_q <= 1'b0;
			rst_pin_q <= 1'b0;
			start_q <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			step_q <= step_d;
			first_q <= first_d;
			err_seen_q <= err_seen_d;
			prev_q <= prev_d;
			exp_q <= exp_d;
			addr_q <= addr_d;
			pass_q <= pass_d;
			fail_q <= fail_d;
			abort_q <= abort_d;
			refused_q <= refused_d;
			fail_lock_q <= fail_lock_d;
			abort_lock_q <= abort_lock_d;
			rst_pin_q <= rst_pin_d;
			start_q <= start_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
		end
	end
	assign fl_rst_n = rst_pin_q;

	// Any non-reset order after a failure is turned away
	property p_no_cmd_after_fail;
		@(posedge pclk) disable iff (!presetn)
		(go && st_q == M_IDLE && fail_lock_q && !is_reset(new_op))
			|=> (refused_q && st_q == M_IDLE);
	endproperty
	a_no_cmd_after_fail: assert property (p_no_cmd_after_fail)
		else $error("order accepted while failure lock set");

	property p_abort_full_reset;
		@(posedge pclk) disable iff (!presetn)
		$fell(abort_lock_q) |-> ($past(op_q) == flash_poll_pkg::OP_RESET3 &&
			$past(step_q) == 2'd2);
	endproperty
	a_abort_full_reset: assert property (p_abort_full_reset)
		else $error("abort lock left without three-write reset");

	property p_toggle_pass;
		@(posedge pclk) disable iff (!presetn)
		(st_q == M_READ && op_q == flash_poll_pkg::OP_TOGGLE_POLL && cyc_done &&
			!first_q && rbyte[6] == prev_q[6]) |=> (pass_q && st_q == M_IDLE);
	endproperty
	a_toggle_pass: assert property (p_toggle_pass)
		else $error("steady toggle bit not taken as completion");

	property p_toggle_needs_two;
		@(posedge pclk) disable iff (!presetn)
		($rose(pass_q) && op_q == flash_poll_pkg::OP_TOGGLE_POLL)
			|-> $past(first_q) == 1'b0;
	endproperty
	a_toggle_needs_two: assert property (p_toggle_needs_two)
		else $error("toggle completion after a single read");

	property p_poll_addr;
		@(posedge pclk) disable iff (!presetn)
		(st_q == M_READ && start_q) |=> (fl_addr == $past(addr_q) && !fl_ce_n);
	endproperty
	a_poll_addr: assert property (p_poll_addr)
		else $error("poll read not at the programmed address");
endmodule
`default_nettype wire

// File: tb/flash_dev_model.sv
/*
 * Behavioural model of the flash device seen through its status word.
 * Assumes the bench starts each embedded operation on op_start and
 * resolves the open-drain ready/busy line with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
	input wire logic fl_oe_n,
	input wire logic fl_we_n,
	input wire logic fl_rst_n,
	input wire logic [15:0] fl_dq_out,
	input wire logic op_start,
	input wire logic [2:0] op_mode,
	input wire logic [3:0] op_len,
	input wire logic [7:0] op_data,
	output logic [15:0] dq_rd,
	output logic rb_low
);
	logic [7:0] array_q;
	logic [7:0] data_q;
	logic [3:0] left;
	logic [2:0] mode;
	logic [1:0] seq;
	logic busy, susp, fail, abort, tog, tog2, poll, shown;
	logic [7:0] st;

	// Poll bit by operation kind
	always_comb begin
		case (mode)
			3'h1: poll = 1'b0;
			3'h2: poll = 1'b1;
			3'h5: poll = susp;
			default: poll = ~data_q[7];
		endcase
	end

	// Status word replaces array data while working; released bus churns
	assign st = {poll, tog, fail, 1'b0, mode == 3'h1 && busy, tog2, abort, 1'b0};
	assign shown = busy | fail | abort | susp;
	assign dq_rd = fl_oe_n ? ({16{tog}} ^ 16'h5A5A) :
		(shown ? {8'h00, st} : {8'h00, array_q});
	assign rb_low = busy;

	// New embedded operation from the bench
	always @(posedge op_start) begin
		mode <= op_mode;
		left <= op_len;
		data_q <= op_data;
		busy <= 1'b1;
		susp <= 1'b0;
		fail <= 1'b0;
		abort <= 1'b0;
	end

	// Each finished read advances toggles and the operation
	always @(posedge fl_oe_n or negedge fl_rst_n) begin
		if (!fl_rst_n) begin
			busy <= 1'b0;
			susp <= 1'b0;
			fail <= 1'b0;
			abort <= 1'b0;
			tog <= 1'b0;
			tog2 <= 1'b0;
			mode <= 3'h0;
		end else begin
			if (busy | fail | abort)
				tog <= ~tog;
			if ((busy | susp) && (mode == 3'h1 || mode == 3'h5))
				tog2 <= ~tog2;
			if (busy && left <= 4'h1) begin
				busy <= 1'b0;
				fail <= mode == 3'h3;
				abort <= mode == 3'h4;
				susp <= mode == 3'h5;
				if (mode < 3'h3)
					array_q <= mode == 3'h0 ? data_q : 8'hFF;
			end else if (busy)
				left <= left - 4'h1;
		end
	end

	// Commands latch on the rising write strobe; abort needs AA/55/F0
	always @(posedge fl_we_n) begin
		if (fl_dq_out[7:0] == 8'hF0 && (!abort || seq == 2'h2)) begin
			fail <= 1'b0;
			abort <= 1'b0;
		end
		if (fl_dq_out[7:0] == 8'hAA)
			seq <= 2'h1;
		else if (fl_dq_out[7:0] == 8'h55 && seq == 2'h1)
			seq <= 2'h2;
		else
			seq <= 2'h0;
	end
endmodule
`default_nettype wire

// File: tb/flash_status_host_tb.sv
/*
 * Self-checking bench for the flash status polling host: table of
 * polling and reset cases, then bus corner cases and a reset in mid-poll.
 * Assumes the device model in flash_dev_model.sv and a 40 MHz pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module flash_status_host_tb;
	typedef struct packed {
		logic [2:0] mode;
		logic [3:0] len;
		logic [7:0] data;
		logic [1:0] op;
		logic [7:0] st;
		logic [7:0] bmask;
		logic [7:0] bexp;
	} row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n;
	logic [flash_poll_pkg::ADDR_W-1:0] fl_addr;
	logic [15:0] fl_dq_out, fl_dq_in;
	logic rb_low, ready_busy_n_in;
	logic op_start = 1'b0;
	logic [2:0] op_mode = 3'h0;
	logic [3:0] op_len = 4'h0;
	logic [7:0] op_data = 8'h00;
	int n_fail = 0;
	int compares = 0;
	row_t rows [11];
	logic [31:0] rd;
	logic err;

	// Clock and pulled-up ready/busy line
	always #12.5 pclk = ~pclk;
	assign ready_busy_n_in = rb_low ? 1'b0 : 1'b1;

	flash_status_host u_flash_status_host (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .fl_addr, .fl_dq_out, .fl_dq_in, .fl_dq_oe_n,
		.fl_ce_n, .fl_oe_n, .fl_we_n, .fl_rst_n, .ready_busy_n_in
	);
	flash_dev_model u_flash_dev_model (
		.fl_oe_n, .fl_we_n, .fl_rst_n, .fl_dq_out, .op_start, .op_mode,
		.op_len, .op_data, .dq_rd(fl_dq_in), .rb_low
	);

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; waits on pready, so no latency is assumed
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads status until busy clears, bounded
	task automatic wait_idle(output logic [31:0] s);
		logic e;
		s = 32'hFFFF_FFFF;
		for (int k = 0; k < 300 && s[0] !== 1'b0; k++)
			apb(1'b0, flash_poll_pkg::REG_STATUS, 32'h0000_0000, s, e);
		// A poll that never ends is a failure, not a silent pass
		if (s[0] !== 1'b0) begin
			n_fail++;
			test_done();
		end
	endtask

	task automatic start_op(input logic [2:0] m, input logic [3:0] n,
		input logic [7:0] d);
		op_mode <= m;
		op_len <= n;
		op_data <= d;
		op_start <= 1'b1;
		@(posedge pclk);
		op_start <= 1'b0;
	endtask

	task automatic test_done();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		test_done();
	end

	// Main sequence
	initial begin
		// mode len data op status byte_mask byte_expect
		rows = '{
			'{3'h0, 4'h3, 8'h5A, 2'h0, 8'h22, 8'hFF, 8'h5A},
			'{3'h0, 4'h4, 8'hA5, 2'h1, 8'h22, 8'hFF, 8'hA5},
			'{3'h1, 4'h3, 8'hFF, 2'h0, 8'h22, 8'hFF, 8'hFF},
			'{3'h1, 4'h2, 8'hFF, 2'h1, 8'h22, 8'hFF, 8'hFF},
			'{3'h2, 4'h3, 8'hFF, 2'h1, 8'h22, 8'hFF, 8'hFF},
			'{3'h5, 4'h2, 8'hFF, 2'h0, 8'h22, 8'h80, 8'h80},
			'{3'h3, 4'h2, 8'h80, 2'h0, 8'h64, 8'hA2, 8'h20},
			'{3'h0, 4'h0, 8'h00, 2'h2, 8'h22, 8'h00, 8'h00},
			'{3'h4, 4'h2, 8'h00, 2'h0, 8'hA8, 8'hA2, 8'h82},
			'{3'h0, 4'h0, 8'h00, 2'h2, 8'hB8, 8'h00, 8'h00},
			'{3'h0, 4'h0, 8'h00, 2'h3, 8'h22, 8'h00, 8'h00}
		};
		repeat (4) @(posedge pclk);
		chk("reset pins", {28'h000_0000, fl_rst_n, fl_ce_n, fl_oe_n, fl_we_n}, 32'h0000_0007);
		presetn <= 1'b1;
		apb(1'b1, flash_poll_pkg::REG_CTRL, 32'h0000_0008, rd, err);
		for (int i = 0; i < 11; i++) begin
			if (rows[i].op < 2'h2)
				start_op(rows[i].mode, rows[i].len, rows[i].data);
			apb(1'b1, flash_poll_pkg::REG_ADDR, 32'h0000_1000 + i, rd, err);
			apb(1'b1, flash_poll_pkg::REG_EXPECT, {24'h00_0000, rows[i].data}, rd, err);
			apb(1'b1, flash_poll_pkg::REG_CTRL, {28'h000_0000, 1'b1, rows[i].op, 1'b1}, rd, err);
			wait_idle(rd);
			chk("status", {24'h00_0000, rd[7:0]}, {24'h00_0000, rows[i].st});
			chk("status byte", {24'h00_0000, rd[15:8] & rows[i].bmask}, {24'h00_0000, rows[i].bexp});
			chk("bus idle", {31'h0000_0000, fl_dq_oe_n}, 32'h0000_0001);
			if (rows[i].op < 2'h2)
				chk("poll address", {8'h00, fl_addr}, 32'h0000_1000 + i);
			// Ordinary order while failure lock holds must be turned away
			if (i == 6) begin
				apb(1'b1, flash_poll_pkg::REG_CTRL, 32'h0000_0009, rd, err);
				apb(1'b0, flash_poll_pkg::REG_STATUS, 32'h0000_0000, rd, err);
				chk("refused after fail", {24'h00_0000, rd[7:0]}, 32'h0000_0074);
			end
			$display("test %0d done", i);
		end
		// Unmapped address answers with an error and zero data
		apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
		chk("unmapped data", rd, 32'h0000_0000);
		chk("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
		// Control fields read back, op is the last order run
		apb(1'b1, flash_poll_pkg::REG_CTRL, 32'h0000_000C, rd, err);
		apb(1'b0, flash_poll_pkg::REG_CTRL, 32'h0000_0000, rd, err);
		chk("ctrl readback", rd, 32'h0000_000E);
		apb(1'b1, flash_poll_pkg::REG_STATUS, 32'hFFFF_FFFF, rd, err);
		apb(1'b0, flash_poll_pkg::REG_STATUS, 32'h0000_0000, rd, err);
		chk("status read only", {24'h00_0000, rd[7:0]}, 32'h0000_0022);
		$display("test bus corners done");
		// Reset in the middle of a long poll
		start_op(3'h0, 4'hF, 8'h11);
		apb(1'b1, flash_poll_pkg::REG_CTRL, 32'h0000_0009, rd, err);
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("mid reset pins", {28'h000_0000, fl_rst_n, fl_ce_n, fl_oe_n, fl_we_n}, 32'h0000_0007);
		presetn <= 1'b1;
		apb(1'b0, flash_poll_pkg::REG_STATUS, 32'h0000_0000, rd, err);
		chk("status after reset", rd, 32'h0000_0020);
		apb(1'b0, flash_poll_pkg::REG_CTRL, 32'h0000_0000, rd, err);
		chk("ctrl after reset", rd, 32'h0000_0000);
		$display("test mid reset done");
		test_done();
	end
endmodule
`default_nettype wire
